/* include/refmux_pkg.sv */
// Constants, register layout and carrier types of the reference clock mux
package refmux_pkg;

	localparam int LANES    = 4;
	localparam int SEL_W    = 3;
	localparam int CHOICE_W = 2;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_RECSEL  = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RINGSEL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LCSEL   = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h10;

	// Reference select codes
	localparam logic [SEL_W-1:0] SEL_RESERVED = 3'h0;
	localparam logic [SEL_W-1:0] SEL_LOCAL0   = 3'h1;
	localparam logic [SEL_W-1:0] SEL_LOCAL1   = 3'h2;
	localparam logic [SEL_W-1:0] SEL_BELOW0   = 3'h3;
	localparam logic [SEL_W-1:0] SEL_BELOW1   = 3'h4;
	localparam logic [SEL_W-1:0] SEL_ABOVE0   = 3'h5;
	localparam logic [SEL_W-1:0] SEL_ABOVE1   = 3'h6;
	localparam logic [SEL_W-1:0] SEL_FABRIC   = 3'h7;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef struct packed {
		logic fabric_test_clock;
		logic from_above_ref_one;
		logic from_above_ref_zero;
		logic from_below_ref_one;
		logic from_below_ref_zero;
		logic local_ref_one;
		logic local_ref_zero;
	} refmux_src_t;

	typedef struct packed {
		logic pair_map;
		logic buffer_enable_low;
	} refmux_ctrl_t;

	typedef struct packed {
		logic [CHOICE_W-1:0] pair_one;
		logic [CHOICE_W-1:0] pair_zero;
	} refmux_recsel_t;

	typedef struct packed {
		logic [SEL_W-1:0] pll_b;
		logic [SEL_W-1:0] pll_a;
	} refmux_lcsel_t;

	typedef logic [LANES-1:0][SEL_W-1:0] refmux_ring_t;

	typedef struct packed {
		logic [1:0]          lc_reserved;
		logic [LANES-1:0]    ring_reserved;
		logic [CHOICE_W-1:0] active_choice;
		logic                buffer_active;
	} refmux_status_t;

	localparam int CTRL_W   = $bits(refmux_ctrl_t);
	localparam int RECSEL_W = $bits(refmux_recsel_t);
	localparam int RING_W   = $bits(refmux_ring_t);
	localparam int LCSEL_W  = $bits(refmux_lcsel_t);
	localparam int STATUS_W = $bits(refmux_status_t);

	// Reset values: buffer powered down, every reference mux on local zero, both pair choices on lane zero
	localparam refmux_ctrl_t   CTRL_RST   = '{pair_map: 1'b0,
		buffer_enable_low: 1'b1};
	localparam refmux_recsel_t RECSEL_RST = '{pair_one: 2'h0,
		pair_zero: 2'h0};
	localparam refmux_ring_t   RING_RST   = {LANES{SEL_LOCAL0}};
	localparam refmux_lcsel_t  LCSEL_RST  = '{pll_b: SEL_LOCAL0,
		pll_a: SEL_LOCAL0};

endpackage : refmux_pkg

/* hw/refmux_top.sv */
// Reference clock selection muxes and recovered clock output buffer
`timescale 1ns/1ns
module refmux_top
	import refmux_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [ADDR_W-1:0]    haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [DATA_W-1:0]    hwdata,
	input  wire logic                 hready,
	output logic      [DATA_W-1:0]    hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [LANES-1:0]     lane_recovered_clock,
	input  wire refmux_src_t          lane_src [LANES],
	input  wire refmux_src_t          lc_src,
	output logic      [LANES-1:0]     ring_ref,
	output logic                      lc_pll_a_ref,
	output logic                      lc_pll_b_ref,
	output logic      [CHOICE_W-1:0]  recovered_choice_pair_zero,
	output logic      [CHOICE_W-1:0]  recovered_choice_pair_one,
	output logic                      recclk_out_p,
	output logic                      recclk_out_n,
	output logic                      recclk_out_oe,
	output logic      [LANES-1:0]     ring_pll_reset_req
);

	// Select one reference source by its three-bit code
	function automatic logic pick_ref(input logic [SEL_W-1:0] code,
		input refmux_src_t src);
		logic ref_clk;
		ref_clk = 1'b0;
		unique case (code)
			SEL_RESERVED: ref_clk = 1'b0;
			SEL_LOCAL0:   ref_clk = src.local_ref_zero;
			SEL_LOCAL1:   ref_clk = src.local_ref_one;
			SEL_BELOW0:   ref_clk = src.from_below_ref_zero;
			SEL_BELOW1:   ref_clk = src.from_below_ref_one;
			SEL_ABOVE0:   ref_clk = src.from_above_ref_zero;
			SEL_ABOVE1:   ref_clk = src.from_above_ref_one;
			SEL_FABRIC:   ref_clk = src.fabric_test_clock;
		endcase
		return ref_clk;
	endfunction : pick_ref

	refmux_ctrl_t                ctrl_r,   ctrl_nxt;
	refmux_recsel_t              recsel_r, recsel_nxt;
	refmux_ring_t                ring_r,   ring_nxt;
	refmux_lcsel_t               lcsel_r,  lcsel_nxt;
	logic      [LANES-1:0]       rstreq_r, rstreq_nxt;
	logic      [ADDR_W-1:0]      addr_r,   addr_nxt;
	logic                        wr_r,     wr_nxt;
	logic                        act_r,    act_nxt;
	logic      [DATA_W-1:0]      rdata_r,  rdata_nxt;
	logic      [CHOICE_W-1:0]    choice;
	refmux_status_t              status;
	logic                        fwd_clk;
	logic                        take;

	// Bus slave, zero wait states
	assign take      = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = rdata_r;

	// Which pair's choice feeds the buffer
	assign choice = ctrl_r.pair_map ? recsel_r.pair_one
		: recsel_r.pair_zero;
	assign recovered_choice_pair_zero = recsel_r.pair_zero;
	assign recovered_choice_pair_one  = recsel_r.pair_one;

	always_comb begin
		status               = '0;
		status.buffer_active = !ctrl_r.buffer_enable_low;
		status.active_choice = choice;
		for (int i = 0; i < LANES; i++) begin
			status.ring_reserved[i] = (ring_r[i] == SEL_RESERVED);
		end
		status.lc_reserved[0] = (lcsel_r.pll_a == SEL_RESERVED);
		status.lc_reserved[1] = (lcsel_r.pll_b == SEL_RESERVED);
	end

	// Register file next state
	always_comb begin
		ctrl_nxt   = ctrl_r;
		recsel_nxt = recsel_r;
		ring_nxt   = ring_r;
		lcsel_nxt  = lcsel_r;
		rstreq_nxt = '0;
		act_nxt    = take;
		addr_nxt   = take ? haddr : addr_r;
		wr_nxt     = take ? hwrite : wr_r;
		rdata_nxt  = rdata_r;
		if (act_r && wr_r) begin
			unique case (addr_r)
				REG_CTRL:
					ctrl_nxt = refmux_ctrl_t'(hwdata[CTRL_W-1:0]);
				REG_RECSEL:
					recsel_nxt = refmux_recsel_t'(hwdata[RECSEL_W-1:0]);
				REG_RINGSEL: begin
					ring_nxt = refmux_ring_t'(hwdata[RING_W-1:0]);
					for (int i = 0; i < LANES; i++) begin
						rstreq_nxt[i] = (ring_nxt[i] != ring_r[i]);
					end
				end
				REG_LCSEL:
					lcsel_nxt = refmux_lcsel_t'(hwdata[LCSEL_W-1:0]);
				default: ;
			endcase
		end
		if (take && !hwrite) begin
			unique case (haddr)
				REG_CTRL:    rdata_nxt = DATA_W'(ctrl_r);
				REG_RECSEL:  rdata_nxt = DATA_W'(recsel_r);
				REG_RINGSEL: rdata_nxt = DATA_W'(ring_r);
				REG_LCSEL:   rdata_nxt = DATA_W'(lcsel_r);
				REG_STATUS:  rdata_nxt = DATA_W'(status);
				default:     rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r   <= CTRL_RST;
			recsel_r <= RECSEL_RST;
			ring_r   <= RING_RST;
			lcsel_r  <= LCSEL_RST;
			rstreq_r <= '0;
			addr_r   <= '0;
			wr_r     <= 1'b0;
			act_r    <= 1'b0;
			rdata_r  <= '0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			recsel_r <= recsel_nxt;
			ring_r   <= ring_nxt;
			lcsel_r  <= lcsel_nxt;
			rstreq_r <= rstreq_nxt;
			addr_r   <= addr_nxt;
			wr_r     <= wr_nxt;
			act_r    <= act_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// Pulse asks the controller to reset the lane's ring PLL
	assign ring_pll_reset_req = rstreq_r;

	// Clock muxes, selects act without a clock
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			ring_ref[i] = pick_ref(ring_r[i], lane_src[i]);
		end
	end
	assign lc_pll_a_ref = pick_ref(lcsel_r.pll_a, lc_src);
	assign lc_pll_b_ref = pick_ref(lcsel_r.pll_b, lc_src);

	// Recovered clock output buffer
	assign fwd_clk       = lane_recovered_clock[choice];
	assign recclk_out_oe = !ctrl_r.buffer_enable_low;
	assign recclk_out_p  = recclk_out_oe && fwd_clk;
	assign recclk_out_n  = recclk_out_oe && !fwd_clk;

	buf_off_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ctrl_r.buffer_enable_low |->
		!recclk_out_oe && !recclk_out_p && !recclk_out_n)
		else $error("buffer drives while disabled");

	buf_on_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!ctrl_r.buffer_enable_low |->
		recclk_out_oe && (recclk_out_n == !recclk_out_p))
		else $error("buffer not driving while enabled");

	fwd_choice_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		recclk_out_oe |-> recclk_out_p == lane_recovered_clock[
		ctrl_r.pair_map ? recovered_choice_pair_one
		: recovered_choice_pair_zero])
		else $error("wrong recovered clock forwarded");

	lane_bit_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(recclk_out_oe && choice == 2'h3) |->
		recclk_out_p == lane_recovered_clock[3])
		else $error("lane three not on bit three");

	lane_zero_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(recclk_out_oe && choice == 2'h0) |->
		recclk_out_p == lane_recovered_clock[0])
		else $error("lane zero not on bit zero");

	pair_choice_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(act_r && wr_r && addr_r == REG_RECSEL) |=>
		{recovered_choice_pair_one, recovered_choice_pair_zero}
		== $past(hwdata[RECSEL_W-1:0]))
		else $error("pair choice not updated");

	ctrl_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(act_r && wr_r && addr_r == REG_CTRL) |=>
		ctrl_r == $past(hwdata[CTRL_W-1:0]))
		else $error("buffer control write lost");

	ring_decode_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[0] == SEL_ABOVE1) |->
		ring_ref[0] == lane_src[0].from_above_ref_one)
		else $error("ring select decode wrong");

	ring_local_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[2] == SEL_LOCAL0) |->
		ring_ref[2] == lane_src[2].local_ref_zero)
		else $error("ring local zero decode wrong");

	ring_fabric_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[2] == SEL_FABRIC) |->
		ring_ref[2] == lane_src[2].fabric_test_clock)
		else $error("ring test clock decode wrong");

	ring_below_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[3] == SEL_BELOW1) |->
		ring_ref[3] == lane_src[3].from_below_ref_one)
		else $error("ring below decode wrong");

	ring_above_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[1] == SEL_ABOVE0) |->
		ring_ref[1] == lane_src[1].from_above_ref_zero)
		else $error("ring above decode wrong");

	ring_rsvd_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_r[1] == SEL_RESERVED) |-> !ring_ref[1])
		else $error("reserved code passes a clock");

	lc_decode_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(lcsel_r.pll_b == SEL_BELOW0) |->
		lc_pll_b_ref == lc_src.from_below_ref_zero)
		else $error("lc select decode wrong");

	lc_local_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(lcsel_r.pll_a == SEL_LOCAL1) |->
		lc_pll_a_ref == lc_src.local_ref_one)
		else $error("lc local one decode wrong");

	lc_rsvd_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(lcsel_r.pll_a == SEL_RESERVED) |-> !lc_pll_a_ref)
		else $error("reserved lc code passes a clock");

	lc_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(act_r && wr_r && addr_r == REG_LCSEL) |=>
		lcsel_r == $past(hwdata[LCSEL_W-1:0]))
		else $error("lc select write lost");

	ring_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(act_r && wr_r && addr_r == REG_RINGSEL) |=>
		ring_r == $past(hwdata[RING_W-1:0]))
		else $error("ring select write lost");

	ring_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(act_r && wr_r && addr_r == REG_RINGSEL) |=>
		$stable(ring_r))
		else $error("ring select moved without a write");

	reset_req_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(act_r && wr_r && addr_r == REG_RINGSEL
		&& hwdata[SEL_W-1:0] != ring_r[0]) |=> ring_pll_reset_req[0] ##1
		!ring_pll_reset_req[0] || $past(act_r && wr_r))
		else $error("ring reset request missing");

	req_quiet_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(act_r && wr_r && addr_r == REG_RINGSEL) |=>
		ring_pll_reset_req == '0)
		else $error("ring reset request without a write");

endmodule : refmux_top

/* tb/refmux_ref_src.sv */
// Model of the oscillators, neighbour groups and lanes feeding the mux
`timescale 1ns/1ns
module refmux_ref_src
	import refmux_pkg::*;
(
	input  wire logic        hclk,
	output refmux_src_t      lane_src [LANES],
	output refmux_src_t      lc_src,
	output logic [LANES-1:0] lane_recovered_clock
);
	// Buffer attributes the integrator fixes; the block has no port for them
	localparam logic       OUTPUT_PATH_ENABLE_ATTR = 1'b1;
	localparam logic [4:0] OUTPUT_DRIVE_TRIM       = 5'h00;

	logic [15:0] pat_r = 16'hace1;
	// Sources step on the falling edge, away from sampling
	always @(negedge hclk) begin
		pat_r <= {pat_r[14:0], pat_r[15] ^ pat_r[13] ^ pat_r[12] ^ pat_r[10]};
	end
	// One input buffer feeds every local zero; remote inputs stay in region
	always_comb begin
		for (int k = 0; k < LANES; k++) begin
			lane_src[k]                = pat_r[k*2 +: 7];
			lane_src[k].local_ref_zero = pat_r[9];
		end
	end
	assign lc_src = pat_r[15:9];
	assign lane_recovered_clock = (pat_r[12:9] ^ pat_r[3:0])
		& {LANES{OUTPUT_PATH_ENABLE_ATTR}};
endmodule : refmux_ref_src

/* tb/tb_refmux_top.sv */
// Self-checking bench for the reference clock mux
`timescale 1ns/1ns
module tb_refmux_top;
	import refmux_pkg::*;
	logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [ADDR_W-1:0]   haddr;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [DATA_W-1:0]   hwdata, hrdata, rd;
	logic                lc_a, lc_b, p, n, oe;
	logic [LANES-1:0]    rec, ring_ref, req;
	logic [CHOICE_W-1:0] ch0, ch1;
	refmux_src_t         lane_src [LANES];
	refmux_src_t         lc_src;
	refmux_ring_t        ring_c;
	refmux_lcsel_t       lc_c;
	refmux_ctrl_t        ctrl_c;
	refmux_recsel_t      rs_c;
	int                  bad_count, compares, cyc;

	refmux_top u_refmux_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .lane_recovered_clock(rec),
		.lane_src(lane_src), .lc_src(lc_src), .ring_ref(ring_ref),
		.lc_pll_a_ref(lc_a), .lc_pll_b_ref(lc_b),
		.recovered_choice_pair_zero(ch0), .recovered_choice_pair_one(ch1),
		.recclk_out_p(p), .recclk_out_n(n), .recclk_out_oe(oe),
		.ring_pll_reset_req(req));
	refmux_ref_src u_refmux_ref_src (.hclk(hclk), .lane_src(lane_src),
		.lc_src(lc_src), .lane_recovered_clock(rec));

	function automatic logic pick(refmux_src_t s, logic [SEL_W-1:0] c);
		case (c)
			SEL_LOCAL0: return s.local_ref_zero;
			SEL_LOCAL1: return s.local_ref_one;
			SEL_BELOW0: return s.from_below_ref_zero;
			SEL_BELOW1: return s.from_below_ref_one;
			SEL_ABOVE0: return s.from_above_ref_zero;
			SEL_ABOVE1: return s.from_above_ref_one;
			SEL_FABRIC: return s.fabric_test_clock;
			default: return 1'b0;
		endcase
	endfunction : pick

	task automatic check(string what, logic [DATA_W-1:0] exp,
		logic [DATA_W-1:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic bus(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic check1(string what, logic exp, logic got);
		check(what, DATA_W'(exp), DATA_W'(got));
	endtask : check1

	task automatic check_outs();
		logic                en;
		logic [CHOICE_W-1:0] s;
		repeat (6) begin
			@(posedge hclk);
			#1;
			en = !ctrl_c.buffer_enable_low;
			s = ctrl_c.pair_map ? rs_c.pair_one : rs_c.pair_zero;
			for (int k = 0; k < LANES; k++) begin
				check1("ring_ref", pick(lane_src[k], ring_c[k]),
					ring_ref[k]);
			end
			check1("lc_a", pick(lc_src, lc_c.pll_a), lc_a);
			check1("lc_b", pick(lc_src, lc_c.pll_b), lc_b);
			check1("oe", en, oe);
			check1("out_p", en & rec[s], p);
			check1("out_n", en & ~rec[s], n);
			check("choice", DATA_W'(rs_c), DATA_W'({ch1, ch0}));
			check("reset_req_idle", 32'h0, DATA_W'(req));
		end
	endtask : check_outs

	task automatic reset_values();
		check_outs();
		bus(1'b0, REG_CTRL, 32'h0);
		check("ctrl", DATA_W'(CTRL_RST), rd);
		bus(1'b0, REG_RINGSEL, 32'h0);
		check("ringsel", DATA_W'(RING_RST), rd);
		bus(1'b0, REG_LCSEL, 32'h0);
		check("lcsel", DATA_W'(LCSEL_RST), rd);
		bus(1'b0, REG_STATUS, 32'h0);
		check("status", 32'h0, rd);
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", 32'h0, rd);
		check1("hresp", HRESP_OKAY, hresp);
	endtask : reset_values

	task automatic buffer_paths();
		for (int c = 0; c < 4; c++) begin
			rs_c = '{pair_one: 2'(3 - c), pair_zero: 2'(c)};
			bus(1'b1, REG_RECSEL, 32'(rs_c));
			for (int m = 0; m < 4; m++) begin
				ctrl_c = refmux_ctrl_t'(2'(m ^ 1));
				bus(1'b1, REG_CTRL, 32'(ctrl_c));
				check_outs();
				bus(1'b0, REG_STATUS, 32'h0);
				check("status_buffer", DATA_W'({(ctrl_c.pair_map ?
					rs_c.pair_one : rs_c.pair_zero),
					!ctrl_c.buffer_enable_low}), DATA_W'(rd[2:0]));
			end
		end
	endtask : buffer_paths

	task automatic ring_codes();
		logic [LANES-1:0] chg, rsv;
		for (int c = 0; c < 8; c++) begin
			for (int k = 0; k < LANES; k++) begin
				chg[k] = ring_c[k] != 3'(c + k);
				rsv[k] = 3'(c + k) == SEL_RESERVED;
				ring_c[k] = 3'(c + k);
			end
			bus(1'b1, REG_RINGSEL, 32'(ring_c));
			#1;
			check("reset_req", DATA_W'(chg), DATA_W'(req));
			check_outs();
			bus(1'b0, REG_STATUS, 32'h0);
			check("status_ring", DATA_W'(rsv), DATA_W'(rd[6:3]));
		end
	endtask : ring_codes

	task automatic lc_codes();
		for (int c = 0; c < 8; c++) begin
			lc_c = '{pll_b: 3'(7 - c), pll_a: 3'(c)};
			bus(1'b1, REG_LCSEL, 32'(lc_c));
			check_outs();
			bus(1'b0, REG_STATUS, 32'h0);
			check("status_lc", DATA_W'({lc_c.pll_b == SEL_RESERVED,
				lc_c.pll_a == SEL_RESERVED}), DATA_W'(rd[8:7]));
		end
	endtask : lc_codes

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Cuts a hang short
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		ring_c = RING_RST;
		lc_c = LCSEL_RST;
		ctrl_c = CTRL_RST;
		rs_c = RECSEL_RST;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		reset_values();
		buffer_paths();
		ring_codes();
		lc_codes();
		print_verdict();
	end
endmodule : tb_refmux_top
